// *** verilog/sdhc_map.svh ***
`ifndef SDHC_MAP_SVH
`define SDHC_MAP_SVH

// drive current codes: 0 -> 0.5 A, 1 -> 1 A, 2 -> 2 A, 3 -> 3.0 A peak
`define SDHC_CUR_W          2
`define SDHC_CUR_RESET      2'h1

// hold setting: 0 full, 1 quarter, 2..32767 samples before enable drops
`define SDHC_HOLD_W         15
`define SDHC_HOLD_RESET     15'h0000
`define SDHC_HOLD_FULL      15'h0000
`define SDHC_HOLD_LOW       15'h0001
`define SDHC_HOLD_TIMED_MIN 15'h0002

// amplifier status query
`define SDHC_QUERY_ARG_W    2
`define SDHC_QUERY_DATA_W   8
`define SDHC_QUERY_ARG_ELO  2'h3
`define SDHC_QUERY_ELO_CODE 8'h03
`define SDHC_QUERY_NONE     8'h00

`endif

// *** verilog/sdhc_pkg.sv ***
package sdhc_pkg;

    // how an axis behaves while resting
    typedef enum logic [1:0] {
        SDHC_HOLD_MODE_FULL,
        SDHC_HOLD_MODE_LOW,
        SDHC_HOLD_MODE_TIMED
    } sdhc_hold_mode_t;

    // emergency lockout sequencing
    typedef enum logic [1:0] {
        SDHC_LO_IDLE,
        SDHC_LO_LOCKED,
        SDHC_LO_OFF_SEEN
    } sdhc_lockout_t;

endpackage : sdhc_pkg

// *** verilog/sdhc_axis_hold.sv ***
`timescale 1ns/1ps
`include "sdhc_map.svh"

module sdhc_axis_hold #(
    parameter int HOLD_W = `SDHC_HOLD_W
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_servo_tick,
    input  wire logic              i_ref_moving,
    input  wire logic [HOLD_W-1:0] i_hold_cfg,
    output logic                   o_quarter,
    output logic                   o_hold_off
);
    import sdhc_pkg::*;

    sdhc_hold_mode_t   mode;
    logic [HOLD_W-1:0] wait_reg;
    logic              quarter_reg;
    logic              hold_off_reg;

    ////////////////////////////////////////////////////////////////////////
    // decode the hold setting
    always_comb
    begin
        if (i_hold_cfg == HOLD_W'(`SDHC_HOLD_FULL))
            mode = SDHC_HOLD_MODE_FULL;                    // [RULE2]
        else if (i_hold_cfg == HOLD_W'(`SDHC_HOLD_LOW))
            mode = SDHC_HOLD_MODE_LOW;                     // [RULE3]
        else
            mode = SDHC_HOLD_MODE_TIMED;                   // [RULE4]
    end

    ////////////////////////////////////////////////////////////////////////
    // count servo samples while resting; any motion restarts the wait
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b || i_ref_moving || mode != SDHC_HOLD_MODE_TIMED)
            wait_reg <= '0;                                // [RULE5]
        else if (i_servo_tick && wait_reg != i_hold_cfg)
            wait_reg <= wait_reg + HOLD_W'(1);             // [RULE4]
    end

    // outputs are registered so the power stage sees clean levels
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            quarter_reg  <= 1'b0;
            hold_off_reg <= 1'b0;
        end
        else
        begin
            quarter_reg  <= !i_ref_moving && mode == SDHC_HOLD_MODE_LOW;   // [RULE3] [RULE5]
            hold_off_reg <= !i_ref_moving && mode == SDHC_HOLD_MODE_TIMED
                            && wait_reg == i_hold_cfg;                     // [RULE4]
        end
    end

    assign o_quarter  = quarter_reg;
    assign o_hold_off = hold_off_reg;

endmodule : sdhc_axis_hold

// *** verilog/sdhc_ctrl.sv ***
// Behaviour
// RULE1 - each axis takes a two-bit current code (0.5 A, 1 A, 2 A, 3.0 A) and resets to code 1.
// RULE2 - hold setting 0, the reset value, keeps full peak current while resting.
// RULE3 - hold setting 1 drops the current to a quarter of peak while resting.
// RULE4 - hold settings 2 to 32767 count servo samples after a move before the enable toggles.
// RULE5 - hold behaviour applies only while the profiler commands no motion on the axis.
// RULE6 - the commander writes the hold setting only once the axis is set up as a stepper.
// RULE7 - hold settings are stored per axis and a write to one axis leaves the others alone.
// RULE8 - the lockout input disables every amplifier in hardware as if motor off.
// RULE9 - while lockout is in force the status query with argument 3 returns 3.
// RULE10 - lockout assertion raises the amplifier-error event for the error handler.
// RULE11 - only motor off followed by servo here, or a reset, re-enables after a lockout.
// RULE12 - the commander should enable shut-down-on-error on all axes when lockout is used.
// RULE13 - a new current code takes effect on the next servo sample and stays until rewritten.
`timescale 1ns/1ps
`include "sdhc_map.svh"

module sdhc_ctrl #(
    parameter int N_AXES = 4,
    parameter int HOLD_W = `SDHC_HOLD_W
) (
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_rst_b,
    input  wire logic                          i_servo_tick,
    input  wire logic [1:0]                    i_axis_sel,
    input  wire logic                          i_cur_wr,
    input  wire logic [`SDHC_CUR_W-1:0]        i_cur_code,
    input  wire logic                          i_hold_wr,
    input  wire logic [HOLD_W-1:0]             i_hold_val,
    input  wire logic [N_AXES-1:0]             i_motor_type_stepper,
    input  wire logic [N_AXES-1:0]             i_ref_moving,
    input  wire logic                          i_emergency_lockout_input,
    input  wire logic [N_AXES-1:0]             i_motor_off_cmd,
    input  wire logic [N_AXES-1:0]             i_servo_here_cmd,
    input  wire logic                          i_amp_status_query,
    input  wire logic [`SDHC_QUERY_ARG_W-1:0]  i_query_arg,
    output logic [N_AXES*`SDHC_CUR_W-1:0]      o_drive_current_select,
    output logic [N_AXES-1:0]                  o_hold_quarter,
    output logic [N_AXES-1:0]                  o_amp_enable,
    output logic                               o_lockout_active,
    output logic                               o_amp_error_event,
    output logic                               o_query_valid,
    output logic [`SDHC_QUERY_DATA_W-1:0]      o_query_data
);
    import sdhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // parameter checks: the axis select is two bits wide
    if (N_AXES < 1 || N_AXES > 4)
    begin : g_bad_axes
        $error("sdhc_ctrl: N_AXES must be 1 to 4");
    end
    if (HOLD_W < 2)
    begin : g_bad_hold
        $error("sdhc_ctrl: HOLD_W must be at least 2");
    end

    // true when a write strobe addresses axis a
    function automatic logic axis_hit(input logic [1:0] sel, input int a);
        axis_hit = (sel == 2'(a));
    endfunction : axis_hit

    logic [`SDHC_CUR_W-1:0]   cur_pend_reg [N_AXES];
    logic [`SDHC_CUR_W-1:0]   cur_live_reg [N_AXES];
    logic [HOLD_W-1:0]        hold_reg     [N_AXES];
    logic [N_AXES-1:0]        quarter;
    logic [N_AXES-1:0]        hold_off;
    logic [N_AXES-1:0]        motor_off_reg;
    logic                     elo_meta_reg;
    logic                     elo_sync_reg;
    logic                     elo_prev_reg;
    logic                     elo_rise;
    sdhc_lockout_t            lo_state_reg;
    logic                     lockout;
    logic                     lo_release;
    logic [N_AXES-1:0]        enable_reg;
    logic                     err_event_reg;
    logic                     query_valid_reg;
    logic [`SDHC_QUERY_DATA_W-1:0] query_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // per-axis current code: written at once, applied on the next sample
    for (genvar a = 0; a < N_AXES; a++)
    begin : g_axis
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
                cur_pend_reg[a] <= `SDHC_CUR_RESET;                 // [RULE1]
            else if (i_cur_wr && axis_hit(i_axis_sel, a))
                cur_pend_reg[a] <= i_cur_code;                      // [RULE1]
        end

        // a write in the same cycle as a tick is picked up one sample later
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
                cur_live_reg[a] <= `SDHC_CUR_RESET;
            else if (i_servo_tick)
                cur_live_reg[a] <= cur_pend_reg[a];                 // [RULE13]
        end

        // hold setting per axis; writes to a non-stepper axis are dropped
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
                hold_reg[a] <= HOLD_W'(`SDHC_HOLD_RESET);           // [RULE2]
            else if (i_hold_wr && axis_hit(i_axis_sel, a)
                     && i_motor_type_stepper[a])                   // [RULE6]
                hold_reg[a] <= i_hold_val;                          // [RULE7]
        end

        sdhc_axis_hold #(
            .HOLD_W (HOLD_W)
        ) u_hold (
            .i_ref_clk    (i_ref_clk),
            .i_rst_b      (i_rst_b),
            .i_servo_tick (i_servo_tick),
            .i_ref_moving (i_ref_moving[a]),
            .i_hold_cfg   (hold_reg[a]),
            .o_quarter    (quarter[a]),
            .o_hold_off   (hold_off[a])
        );

        assign o_drive_current_select[a*`SDHC_CUR_W +: `SDHC_CUR_W] = cur_live_reg[a];
    end

    ////////////////////////////////////////////////////////////////////////
    // lockout pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            elo_meta_reg <= 1'b0;
            elo_sync_reg <= 1'b0;
            elo_prev_reg <= 1'b0;
        end
        else
        begin
            elo_meta_reg <= i_emergency_lockout_input;
            elo_sync_reg <= elo_meta_reg;
            elo_prev_reg <= elo_sync_reg;
        end
    end

    assign elo_rise = elo_sync_reg && !elo_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // lockout latch: held until motor off then servo here with the pin low
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            lo_state_reg <= SDHC_LO_IDLE;
        else
        begin
            unique case (lo_state_reg)
                SDHC_LO_IDLE:
                    if (elo_sync_reg)
                        lo_state_reg <= SDHC_LO_LOCKED;                  // [RULE8]
                SDHC_LO_LOCKED:
                    if (|i_motor_off_cmd && !elo_sync_reg)
                        lo_state_reg <= SDHC_LO_OFF_SEEN;                // [RULE11]
                SDHC_LO_OFF_SEEN:
                    if (elo_sync_reg)
                        lo_state_reg <= SDHC_LO_LOCKED;
                    else if (|i_servo_here_cmd)
                        lo_state_reg <= SDHC_LO_IDLE;                    // [RULE11]
                default:
                    lo_state_reg <= SDHC_LO_LOCKED;  // illegal code fails safe
            endcase
        end
    end

    assign lockout = (lo_state_reg != SDHC_LO_IDLE) || elo_sync_reg;

    // the servo here that ends a lockout must clear motor off in that same cycle,
    // otherwise the still-high lockout term would keep every axis off for good
    assign lo_release = (lo_state_reg == SDHC_LO_OFF_SEEN) && !elo_sync_reg
                        && |i_servo_here_cmd;                           // [RULE11]

    ////////////////////////////////////////////////////////////////////////
    // per-axis motor-off state; lockout forces every axis off
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            motor_off_reg <= '0;
        else
            for (int a = 0; a < N_AXES; a++)
                if ((lockout && !lo_release) || i_motor_off_cmd[a])
                    motor_off_reg[a] <= 1'b1;                    // [RULE8]
                else if (i_servo_here_cmd[a])
                    motor_off_reg[a] <= 1'b0;                    // [RULE11]
    end

    // enable drops for off, lockout, or an expired timed hold
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            enable_reg <= '0;
        else
            enable_reg <= ~motor_off_reg & ~hold_off
                          & {N_AXES{!lockout}};               // [RULE8] [RULE4]
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle error event on each new lockout assertion
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            err_event_reg <= 1'b0;
        else
            err_event_reg <= elo_rise;                           // [RULE10]
    end

    ////////////////////////////////////////////////////////////////////////
    // status query: answer the cycle after the request
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            query_valid_reg <= 1'b0;
            query_data_reg  <= `SDHC_QUERY_NONE;
        end
        else
        begin
            query_valid_reg <= i_amp_status_query;
            if (i_amp_status_query)
                query_data_reg <= (i_query_arg == `SDHC_QUERY_ARG_ELO && lockout)
                                  ? `SDHC_QUERY_ELO_CODE                 // [RULE9]
                                  : `SDHC_QUERY_NONE;
        end
    end

    assign o_hold_quarter    = quarter & ~motor_off_reg;
    assign o_amp_enable      = enable_reg;
    assign o_lockout_active  = lockout;
    assign o_amp_error_event = err_event_reg;
    assign o_query_valid     = query_valid_reg;
    assign o_query_data      = query_data_reg;

endmodule : sdhc_ctrl

// *** verif/sdhc_ctrl_assertions.sv ***
`timescale 1ns/1ps
module sdhc_ctrl_assertions #(
    parameter int N_AXES = 4
) (
    input wire logic                i_ref_clk,
    input wire logic                i_rst_b,
    input wire logic                i_servo_tick,
    input wire logic [N_AXES-1:0]   i_ref_moving,
    input wire logic [N_AXES-1:0]   i_servo_here_cmd,
    input wire logic                i_amp_status_query,
    input wire logic [1:0]          i_query_arg,
    input wire logic [N_AXES*2-1:0] o_drive_current_select,
    input wire logic [N_AXES-1:0]   o_hold_quarter,
    input wire logic [N_AXES-1:0]   o_amp_enable,
    input wire logic                o_lockout_active,
    input wire logic                o_amp_error_event,
    input wire logic                o_query_valid,
    input wire logic [7:0]          o_query_data
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    // query answers one cycle later, code 3 for argument 3 while locked out
    chk_query_answer: assert property (i_amp_status_query |=> o_query_valid)
        else $error("query not answered");
    chk_query_cause: assert property (o_query_valid |-> $past(i_amp_status_query))
        else $error("query answer without request");
    chk_query_code: assert property (i_amp_status_query && i_query_arg == 2'h3
        && o_lockout_active |=> o_query_data == 8'h03) else $error("lockout code wrong");
    // lockout kills every enable and fires the error event once
    chk_lock_disable: assert property (o_lockout_active |=> o_amp_enable == '0)
        else $error("amplifier left enabled in lockout");
    chk_event_rise: assert property ($rose(o_lockout_active) |=> o_amp_error_event)
        else $error("no error event at lockout");
    chk_event_once: assert property (o_amp_error_event |=> !o_amp_error_event)
        else $error("error event longer than one cycle");
    chk_recover_seq: assert property ($fell(o_lockout_active) |->
        $past(i_servo_here_cmd) != '0) else $error("lockout cleared without servo here");
    // current codes move only on a servo sample; quarter only on a resting axis
    chk_code_tick: assert property ($changed(o_drive_current_select)
        |-> $past(i_servo_tick)) else $error("current code changed off a sample");
    chk_quarter_rest: assert property ((o_hold_quarter & $past(i_ref_moving)) == '0)
        else $error("quarter current on a moving axis");
    cover property (o_amp_error_event);
    cover property (o_query_valid && o_query_data == 8'h03);
    cover property (o_hold_quarter != '0);
endmodule : sdhc_ctrl_assertions

bind sdhc_ctrl sdhc_ctrl_assertions #(.N_AXES(N_AXES)) u_chk (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_servo_tick(i_servo_tick), .i_ref_moving(i_ref_moving),
    .i_servo_here_cmd(i_servo_here_cmd), .i_amp_status_query(i_amp_status_query),
    .i_query_arg(i_query_arg), .o_drive_current_select(o_drive_current_select),
    .o_hold_quarter(o_hold_quarter), .o_amp_enable(o_amp_enable),
    .o_lockout_active(o_lockout_active), .o_amp_error_event(o_amp_error_event),
    .o_query_valid(o_query_valid), .o_query_data(o_query_data));

// *** verif/sdhc_cmd_model.sv ***
`timescale 1ns/1ps
module sdhc_cmd_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_recover,
    input  wire logic       i_here_only,
    output logic            o_servo_tick,
    output logic [3:0]      o_stepper,
    output logic [3:0]      o_motor_off,
    output logic [3:0]      o_servo_here
);
    logic [1:0] tick_cnt;
    logic [1:0] rec_cnt;
    logic       rec_q;
    logic       here_q;
    // axis 3 stays a servo axis, so hold writes to it are out of order on purpose
    assign o_stepper = 4'h7;
    initial
    begin
        tick_cnt = 2'h0;
        rec_cnt = 2'h0;
        o_servo_tick = 1'b0;
        o_motor_off = 4'h0;
        o_servo_here = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // requests from the bench change at the falling edge, so take them at the rising one
    always @(posedge i_ref_clk)
    begin
        rec_q <= i_recover;
        here_q <= i_here_only;
    end
    // sample strobe every fourth cycle; recovery is motor off, then servo here
    always @(negedge i_ref_clk)
    begin
        tick_cnt <= tick_cnt + 2'h1;
        o_servo_tick <= (tick_cnt == 2'h3);
        rec_cnt <= rec_q ? 2'h1 : ((rec_cnt != 2'h0) ? rec_cnt + 2'h1 : 2'h0);
        o_motor_off <= {4{rec_cnt == 2'h1}};
        o_servo_here <= {4{rec_cnt == 2'h3 || here_q}};
    end
endmodule : sdhc_cmd_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        ref_clk, rst_b, tick, cur_wr, hold_wr, lock_pin, query, recover, here_only;
    logic [1:0]  sel, cur_code, qarg;
    logic [14:0] hold_val;
    logic [3:0]  stepper, moving, moff, shere, quarter, amp_en;
    logic [7:0]  cur_sel, q_data;
    logic        lock_act, err_ev, q_valid;
    int          errors = 0;
    int          checks = 0;
    int          n;
    sdhc_ctrl uut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_servo_tick(tick), .i_axis_sel(sel),
        .i_cur_wr(cur_wr), .i_cur_code(cur_code), .i_hold_wr(hold_wr), .i_hold_val(hold_val),
        .i_motor_type_stepper(stepper), .i_ref_moving(moving),
        .i_emergency_lockout_input(lock_pin), .i_motor_off_cmd(moff),
        .i_servo_here_cmd(shere), .i_amp_status_query(query), .i_query_arg(qarg),
        .o_drive_current_select(cur_sel), .o_hold_quarter(quarter), .o_amp_enable(amp_en),
        .o_lockout_active(lock_act), .o_amp_error_event(err_ev), .o_query_valid(q_valid),
        .o_query_data(q_data));
    sdhc_cmd_model u_cmd (.i_ref_clk(ref_clk), .i_recover(recover), .i_here_only(here_only),
        .o_servo_tick(tick), .o_stepper(stepper), .o_motor_off(moff), .o_servo_here(shere));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // write strobes stay up across back-to-back calls; rest drops them afterwards
    task automatic wr(input logic h, input logic [1:0] a, input logic [14:0] v);
        sel = a;
        cur_code = v[1:0];
        hold_val = v;
        cur_wr = !h;
        hold_wr = h;
        cyc(1);
    endtask : wr
    task automatic rest;
        cur_wr = 1'b0;
        hold_wr = 1'b0;
        query = 1'b0;
    endtask : rest
    task automatic ask(input logic [1:0] a, input logic [7:0] exp);
        qarg = a;
        query = 1'b1;
        cyc(1);
        chk("query valid", 16'h1, q_valid);
        chk("query data", exp, q_data);
    endtask : ask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    // resets, current codes, hold modes, lockout and recovery in one sequence
    initial
    begin
        {rst_b, cur_wr, hold_wr, lock_pin, query, recover, here_only} = 7'h0;
        {sel, cur_code, qarg, hold_val, moving} = 25'h0;
        cyc(2);
        rst_b = 1'b1;
        cyc(3);
        chk("current codes", 16'h55, cur_sel);
        chk("enables", 16'hf, amp_en);
        chk("quarter", 16'h0, quarter);
        $display("test reset finished");
        for (int c = 0; c < 4; c++)
            wr(1'b0, c[1:0], 15'(c));
        wr(1'b0, 2'h0, 15'h3);
        wr(1'b0, 2'h0, 15'h2);
        rest();
        cyc(6);
        chk("current codes", 16'he6, cur_sel);
        $display("test current finished");
        wr(1'b1, 2'h0, 15'h1);
        wr(1'b1, 2'h3, 15'h1);
        rest();
        cyc(4);
        chk("quarter", 16'h1, quarter);
        moving = 4'h1;
        cyc(2);
        chk("quarter moving", 16'h0, quarter);
        moving = 4'h4;
        wr(1'b1, 2'h2, 15'h2);
        rest();
        cyc(2);
        chk("quarter rest", 16'h1, quarter);
        chk("enables moving", 16'hf, amp_en);
        moving = 4'h0;
        cyc(2);
        chk("enables early", 16'hf, amp_en);
        cyc(14);
        chk("enables timed", 16'hb, amp_en);
        moving = 4'h4;
        cyc(3);
        chk("enables back", 16'hf, amp_en);
        $display("test hold finished");
        lock_pin = 1'b1;
        n = 0;
        while (err_ev !== 1'b1 && n < 6)
        begin
            cyc(1);
            n++;
        end
        chk("error event", 16'h1, err_ev);
        if (err_ev !== 1'b1)
            wrap_up();
        cyc(1);
        chk("lockout", 16'h1, lock_act);
        chk("enables locked", 16'h0, amp_en);
        ask(2'h3, 8'h03);
        ask(2'h0, 8'h00);
        rest();
        lock_pin = 1'b0;
        here_only = 1'b1;
        cyc(1);
        here_only = 1'b0;
        cyc(5);
        chk("lockout held", 16'h1, lock_act);
        recover = 1'b1;
        cyc(1);
        recover = 1'b0;
        cyc(8);
        chk("lockout cleared", 16'h0, lock_act);
        chk("enables restored", 16'hf, amp_en);
        ask(2'h3, 8'h00);
        $display("test lockout finished");
        wrap_up();
    end
endmodule : tb
